//--- inc/network_timing_defs.vh
// Constants for the network timing source selector
`ifndef NETWORK_TIMING_DEFS_VH
`define NETWORK_TIMING_DEFS_VH
`define SYS_CLK_HZ 50000000
`define NS_PER_S 1000000000
`define HOLD_S 5'h05
`define UNLOCK_WAIT_S 5'h0f
`define SEARCH_S 5'h0f
`define LOCK_GAP_NS 640
`define LOCK_GAP_CYC ((`LOCK_GAP_NS * (`SYS_CLK_HZ / 1000000)) / 1000)
`define ADDR_CTRL 5'h00
`define ADDR_PORT_CFG 5'h04
`define ADDR_LVL_ADDR 5'h08
`define ADDR_LVL_DATA 5'h0c
`define ADDR_STATUS 5'h10
`define CTRL_HOP_SEARCH 1
`define CTRL_RESTART 2
`define CTRL_ADDR_LSB 8
`define CTRL_LAST_LSB 16
`define PCFG_FAC_LSB 4
`define PCFG_TXS_LSB 8
`define PCFG_PREF_LSB 12
`define MODE_INT 2'h0
`define MODE_EXT 2'h1
`define MODE_FAC 2'h2
`define MODE_SLAVE 2'h3
`define REF_INT 3'h4
`define REF_EXT 3'h5
`define LEVEL_FIRST 5'h01
`define LEVEL_LAST 5'h1f
`define LEVEL_NONE 5'h00
`define HOPS_MAX 4'hf
`define CTRL_RESET 32'h001f_0002
`endif

//--- test/neighbor_nodes.sv
// Neighbor node model: trunk timing, reference timing and status
`timescale 1ns/1ps
module neighbor_nodes #(
    parameter int TICK_CYCLES = 64
)(
    input wire sys_clk,
    input wire rst_b,
    input wire [3:0] run,
    input wire ext_run,
    input wire [19:0] lvl,
    input wire [15:0] hops,
    input wire [3:0] lck,
    input wire [3:0] am,
    input wire [31:0] addr,
    output logic [3:0] port_rx_clk,
    output logic reference_timing_input,
    output logic [19:0] nbr_level,
    output logic [15:0] nbr_hops,
    output logic [3:0] nbr_locked,
    output logic [3:0] nbr_automaster,
    output logic [31:0] nbr_addr
);
    int cnt;
    // ====
    // One generator, 160 ns; a dead trunk holds its line low
    initial
    begin
        port_rx_clk = 4'h0;
        reference_timing_input = 1'b0;
        #7;
        forever
        begin
            #80;
            port_rx_clk = ~port_rx_clk & run;
            reference_timing_input = ~reference_timing_input & ext_run;
        end
    end
    // ====
    // Status sent once every TICK_CYCLES clocks
    always @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cnt <= 0;
            nbr_level <= 20'h0;
            nbr_hops <= 16'h0;
            nbr_locked <= 4'h0;
            nbr_automaster <= 4'h0;
            nbr_addr <= 32'h0;
        end
        else if (cnt == TICK_CYCLES - 1)
        begin
            cnt <= 0;
            nbr_level <= lvl;
            nbr_hops <= hops;
            nbr_locked <= lck;
            nbr_automaster <= am;
            nbr_addr <= addr;
        end
        else
        begin
            cnt <= cnt + 1;
        end
    end
endmodule // neighbor_nodes

//--- test/nts_asserts.sv
// Port checker for the timing source selector
`timescale 1ns/1ps
module nts_checker #(
    parameter int TICK_CYCLES = 64
)(
    input wire sys_clk,
    input wire rst_b,
    input wire clk_en,
    input wire avs_read,
    input wire avs_write,
    input wire avs_waitrequest,
    input wire osc_fault,
    input wire [2:0] ref_sel,
    input wire tx_status_strobe,
    input wire int_clk_fail,
    input wire ext_ref_fail,
    input wire [3:0] trunk_fault
);
    // ====
    // Properties
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);
    sequence s_req;
        (avs_read || avs_write) && avs_waitrequest && clk_en;
    endsequence
    sequence s_quiet;
        !tx_status_strobe [*8];
    endsequence
    property p_bus_answer;
        s_req |=> !avs_waitrequest;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");
    property p_bus_pulse;
        !avs_waitrequest |=> avs_waitrequest;
    endproperty
    a_bus_pulse: assert property (p_bus_pulse) else $error("bus answer too long");
    property p_tick_pulse;
        tx_status_strobe |=> s_quiet;
    endproperty
    a_tick_pulse: assert property (p_tick_pulse) else $error("status strobe too long");
    property p_tick_period;
        tx_status_strobe |-> ##TICK_CYCLES tx_status_strobe;
    endproperty
    a_tick_period: assert property (p_tick_period) else $error("status strobe period");
    property p_osc_set;
        osc_fault [*5] |-> int_clk_fail;
    endproperty
    a_osc_set: assert property (p_osc_set) else $error("oscillator alarm missing");
    property p_osc_clr;
        !osc_fault [*5] |-> !int_clk_fail;
    endproperty
    a_osc_clr: assert property (p_osc_clr) else $error("oscillator alarm stuck");
    property p_ext_sticky;
        ext_ref_fail |=> ext_ref_fail;
    endproperty
    a_ext_sticky: assert property (p_ext_sticky) else $error("reference alarm dropped");
    property p_loss_internal;
        $rose(|trunk_fault) |-> ##[0:1] ref_sel == 3'h4;
    endproperty
    a_loss_internal: assert property (p_loss_internal) else $error("no internal on loss");
endmodule // nts_checker

bind network_timing_source_select nts_checker #(.TICK_CYCLES(TICK_CYCLES)) u_nts_checker (
    .sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en), .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .osc_fault(osc_fault), .ref_sel(ref_sel),
    .tx_status_strobe(tx_status_strobe), .int_clk_fail(int_clk_fail), .ext_ref_fail(ext_ref_fail),
    .trunk_fault(trunk_fault)
);

//--- test/tb.sv
// Self-checking bench of the timing source selector
`timescale 1ns/1ps
`include "network_timing_defs.vh"
module tb;
    localparam int TICK = 64;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [4:0] adr = 5'h00;
    logic rd = 1'b0, wr = 1'b0, osc = 1'b0, ext_run = 1'b0, seen2;
    logic [31:0] wd = 32'h0, naddr = 32'h0, rdv, v;
    logic [3:0] run = 4'h0, lck = 4'h0, am = 4'h0;
    logic [19:0] lvl = 20'h0;
    logic [15:0] hops = 16'h0;
    int p;
    int n_mismatch = 0;
    int samples_checked = 0;
    wire [31:0] rdat, nad;
    wire [19:0] nlv;
    wire [15:0] nhp;
    wire [3:0] rxc, nlk, nam, txs, thp, tf;
    wire [2:0] rsel;
    wire [4:0] tlv;
    wire wt, refc, tlk, tam, tst, icf, erf;

    neighbor_nodes #(.TICK_CYCLES(TICK)) nbrs (
        .sys_clk(sys_clk), .rst_b(rst_b), .run(run), .ext_run(ext_run), .lvl(lvl), .hops(hops),
        .lck(lck), .am(am), .addr(naddr), .port_rx_clk(rxc), .reference_timing_input(refc),
        .nbr_level(nlv), .nbr_hops(nhp), .nbr_locked(nlk), .nbr_automaster(nam), .nbr_addr(nad)
    );
    network_timing_source_select #(.TICK_CYCLES(TICK)) DUT (
        .sys_clk(sys_clk), .rst_b(rst_b), .clk_en(1'b1), .avs_address(adr), .avs_read(rd),
        .avs_write(wr), .avs_writedata(wd), .avs_readdata(rdat), .avs_waitrequest(wt),
        .port_rx_clk(rxc), .reference_timing_input(refc), .osc_fault(osc), .nbr_level(nlv),
        .nbr_hops(nhp), .nbr_locked(nlk), .nbr_automaster(nam), .nbr_addr(nad), .ref_sel(rsel),
        .tx_timing_sel(txs), .tx_level(tlv), .tx_hops(thp), .tx_locked(tlk), .tx_automaster(tam),
        .tx_status_strobe(tst), .int_clk_fail(icf), .ext_ref_fail(erf), .trunk_fault(tf)
    );

    // ====
    // Tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        adr <= a;
        wd <= d;
        rd <= !w;
        wr <= w;
        @(posedge sys_clk);
        while (wt !== 1'b0 && n < 100)
        begin
            @(posedge sys_clk);
            n++;
        end
        if (n >= 100)
            n_mismatch++;
        rdv = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic lv(input logic [4:0] l, input logic [1:0] m);
        bus(1'b1, `ADDR_LVL_ADDR, {27'h0, l});
        bus(1'b1, `ADDR_LVL_DATA, {30'h0, m});
    endtask
    task automatic pcfg(input logic [3:0] av, input logic [3:0] fac);
        bus(1'b1, `ADDR_PORT_CFG, {24'h0, fac, av});
    endtask
    task automatic ctl();
        bus(1'b1, `ADDR_CTRL, 32'h0002_0706);
    endtask
    task automatic tick();
        @(posedge sys_clk);
        while (tst !== 1'b1)
            @(posedge sys_clk);
    endtask
    task automatic wsel(input logic [2:0] e, input int nt);
        int n;
        n = 0;
        while (rsel !== e && n < nt)
        begin
            tick();
            n++;
        end
    endtask
    task automatic done(input string s);
        $display("test %s finished", s);
    endtask
    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Reference choice: locked, available, level not worse, then fewer hops
    function automatic int pick(input int cur, input logic [3:0] av);
        int b;
        b = -1;
        for (int i = 0; i < 4; i++)
            if (av[i] && lck[i] && lvl[5*i +: 5] != 0 && lvl[5*i +: 5] <= cur)
                if (b < 0 || lvl[5*i +: 5] < lvl[5*b +: 5]
                    || (lvl[5*i +: 5] == lvl[5*b +: 5] && hops[4*i +: 4] < hops[4*b +: 4]))
                    b = i;
        return b;
    endfunction

    // ====
    // Clock and watchdog
    initial
    begin
        forever
            #10 sys_clk = ~sys_clk;
    end
    initial
    begin
        repeat (40000) @(posedge sys_clk);
        n_mismatch++;
        wrap_up();
    end

    // ====
    // Tests
    initial
    begin
        void'($urandom(40));
        repeat (10) @(posedge sys_clk);
        chk(32'(rsel), 32'h4);
        chk(32'(tlv), 32'h0);
        chk(32'(thp), 32'hf);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        bus(1'b0, `ADDR_CTRL, 32'h0);
        chk(rdv, `CTRL_RESET);
        bus(1'b0, 5'h14, 32'h0);
        chk(rdv, 32'h0);
        lv(5'h01, `MODE_INT);
        lv(5'h02, `MODE_SLAVE);
        pcfg(4'h7, 4'h0);
        ctl();
        bus(1'b0, `ADDR_CTRL, 32'h0);
        chk(rdv, 32'h0002_0702);
        tick();
        tick();
        chk(32'(rsel), 32'h4);
        chk(32'(tlv), 32'h1);
        chk(32'(thp), 32'h0);
        done("internal master");
        repeat (3)
        begin
            v = $urandom & 32'h000f_ff0f;
            bus(1'b1, `ADDR_PORT_CFG, v);
            bus(1'b0, `ADDR_PORT_CFG, 32'h0);
            chk(rdv, v);
            chk(32'(txs), 32'(v[11:8]));
        end
        done("transmit select");
        lv(5'h01, `MODE_EXT);
        pcfg(4'h7, 4'h0);
        ext_run <= 1'b1;
        ctl();
        wsel(3'h5, 4);
        chk(32'(rsel), 32'h5);
        chk(32'(erf), 32'h0);
        ext_run <= 1'b0;
        repeat (3) tick();
        chk(32'(erf), 32'h1);
        done("external reference");
        ext_run <= 1'b1;
        pcfg(4'hf, 4'h4);
        run <= 4'h4;
        ctl();
        wsel(3'h2, 4);
        chk(32'(rsel), 32'h2);
        run <= 4'h0;
        repeat (60) @(posedge sys_clk);
        chk(32'(tf), 32'h4);
        done("carrier trunk");
        lv(5'h01, `MODE_SLAVE);
        pcfg(4'h7, 4'h0);
        run <= 4'hf;
        lck <= 4'hb;
        lvl <= {5'h02, 5'h01, 5'h01, 5'h01};
        hops <= 16'h0013;
        tick();
        tick();
        p = pick(1, 4'h7);
        ctl();
        wsel(3'(p), 20);
        chk(32'(rsel), 32'(p));
        tick();
        tick();
        chk(32'(thp), 32'(hops[4*p +: 4]) + 32'h1);
        run <= 4'hd;
        lck <= 4'h9;
        lvl <= {5'h02, 5'h01, 5'h00, 5'h01};
        repeat (60) @(posedge sys_clk);
        chk(32'(tf[1]), 32'h1);
        chk(32'(rsel), 32'h4);
        repeat (7) tick();
        chk(32'(tlk), 32'h0);
        p = pick(1, 4'h7);
        wsel(3'(p), 30);
        chk(32'(rsel), 32'(p));
        done("slave loss");
        run <= 4'h0;
        lck <= 4'h0;
        lvl <= 20'h0;
        seen2 = 1'b0;
        p = 0;
        while (tam !== 1'b1 && p < 150)
        begin
            tick();
            p++;
            if (tlv === 5'h02)
                seen2 = 1'b1;
        end
        chk(32'(seen2), 32'h1);
        chk(32'(tam), 32'h1);
        chk(32'(rsel), 32'h4);
        am <= 4'h1;
        naddr <= 32'h0000_0903;
        run <= 4'h1;
        wsel(3'h0, 6);
        chk(32'(rsel), 32'h0);
        done("fallback");
        osc <= 1'b1;
        repeat (8) @(posedge sys_clk);
        chk(32'(icf), 32'h1);
        osc <= 1'b0;
        done("oscillator fault");
        wrap_up();
    end
endmodule // tb

//--- verilog/network_timing_source_select.v
// Network timing source selector with level fallback and status exchange
`timescale 1ns/1ps
`include "network_timing_defs.vh"
module network_timing_source_select #(
    parameter TICK_CYCLES = `SYS_CLK_HZ
)(
    input wire sys_clk,
    input wire rst_b,
    input wire clk_en,
    input wire [4:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    input wire [3:0] port_rx_clk,
    input wire reference_timing_input,
    input wire osc_fault,
    input wire [19:0] nbr_level,
    input wire [15:0] nbr_hops,
    input wire [3:0] nbr_locked,
    input wire [3:0] nbr_automaster,
    input wire [31:0] nbr_addr,
    output reg [2:0] ref_sel,
    output reg [3:0] tx_timing_sel,
    output reg [4:0] tx_level,
    output reg [3:0] tx_hops,
    output reg tx_locked,
    output reg tx_automaster,
    output reg tx_status_strobe,
    output reg int_clk_fail,
    output reg ext_ref_fail,
    output reg [3:0] trunk_fault
);
localparam ST_APPLY = 3'h0;
localparam ST_LOCKED = 3'h1;
localparam ST_HOLD = 3'h2;
localparam ST_UNLOCKED = 3'h3;
localparam ST_SEARCH = 3'h4;
localparam ST_AUTO = 3'h5;
localparam integer GAP_INT = `LOCK_GAP_CYC;
localparam [5:0] GAP_CYC = GAP_INT[5:0];
localparam [4:0] HOLD_S = `HOLD_S;
localparam [4:0] WAIT_S = `UNLOCK_WAIT_S;
localparam [4:0] SEARCH_S = `SEARCH_S;
// ============================================================
// Pin synchronisers and edge finders
wire [4:0] pin_in = {reference_timing_input, port_rx_clk};
reg [4:0] sync1_reg;
reg [4:0] sync2_reg;
reg [4:0] sync3_reg;
reg osc1_reg;
reg osc2_reg;
wire [4:0] rise;
genvar gi;
generate
    for (gi = 0; gi < 5; gi = gi + 1)
    begin : g_sync
        always @(posedge sys_clk or negedge rst_b)
        begin
            if (!rst_b)
            begin
                sync1_reg[gi] <= 1'b0;
                sync2_reg[gi] <= 1'b0;
                sync3_reg[gi] <= 1'b0;
            end
            else if (clk_en)
            begin
                sync1_reg[gi] <= pin_in[gi];
                sync2_reg[gi] <= sync1_reg[gi];
                sync3_reg[gi] <= sync2_reg[gi];
            end
        end
        assign rise[gi] = sync2_reg[gi] & ~sync3_reg[gi];
    end
endgenerate
// ============================================================
// Registers
reg [31:0] ctrl_reg;
reg [19:0] port_cfg_reg;
reg [4:0] lvl_addr_reg;
reg [3:0] level_table [0:31];
reg [2:0] state_reg;
reg [4:0] level_reg;
reg [3:0] hops_reg;
reg [1:0] src_port_reg;
reg [4:0] sec_cnt_reg;
reg [31:0] tick_cnt_reg;
reg [5:0] gap_cnt_reg;
reg [2:0] ref_prev_reg;
reg restart_reg;
wire req = avs_read | avs_write;
wire done = req & ~avs_waitrequest;
wire hop_search = ctrl_reg[`CTRL_HOP_SEARCH];
wire [7:0] node_addr = ctrl_reg[`CTRL_ADDR_LSB +: 8];
wire [4:0] last_level = ctrl_reg[`CTRL_LAST_LSB +: 5];
wire [3:0] avail = port_cfg_reg[3:0];
wire [3:0] facility = port_cfg_reg[`PCFG_FAC_LSB +: 4];
wire tick = (tick_cnt_reg == TICK_CYCLES - 1);
wire [3:0] cfg_entry = level_table[level_reg];
wire [1:0] cfg_mode = cfg_entry[1:0];
wire [1:0] cfg_port = cfg_entry[3:2];
wire [3:0] fac_avail = facility & avail;
wire [1:0] fac_first = fac_avail[0] ? 2'h0 : fac_avail[1] ? 2'h1 : fac_avail[2] ? 2'h2 : 2'h3;
wire [1:0] fac_port = ((cfg_mode == `MODE_FAC) & fac_avail[cfg_port]) ? cfg_port : fac_first;
// ============================================================
// Avalon slave: one wait cycle, then answer
always @(posedge sys_clk or negedge rst_b)
begin
    if (!rst_b)
    begin
        avs_waitrequest <= 1'b1;
        avs_readdata <= 32'h0000_0000;
        ctrl_reg <= `CTRL_RESET;
        port_cfg_reg <= 20'h0_0000;
        lvl_addr_reg <= `LEVEL_FIRST;
        tx_timing_sel <= 4'h0;
        restart_reg <= 1'b0;
    end
    else if (clk_en)
    begin
        restart_reg <= 1'b0;
        avs_waitrequest <= ~(req & avs_waitrequest);
        if (req & avs_waitrequest)
        begin
            case (avs_address)
                `ADDR_CTRL: avs_readdata <= ctrl_reg;
                `ADDR_PORT_CFG: avs_readdata <= {12'h000, port_cfg_reg};
                `ADDR_LVL_ADDR: avs_readdata <= {27'h000_0000, lvl_addr_reg};
                `ADDR_LVL_DATA: avs_readdata <= {28'h000_0000, level_table[lvl_addr_reg]};
                `ADDR_STATUS: avs_readdata <= {int_clk_fail, ext_ref_fail, trunk_fault, 7'h00,
                    tx_locked, tx_automaster, src_port_reg, state_reg, hops_reg, 3'h0, level_reg};
                default: avs_readdata <= 32'h0000_0000;
            endcase
        end
        if (done & avs_write)
        begin
            case (avs_address)
                `ADDR_CTRL:
                begin
                    ctrl_reg <= {avs_writedata[31:3], 1'b0, avs_writedata[1:0]};
                    restart_reg <= avs_writedata[`CTRL_RESTART];
                end
                `ADDR_PORT_CFG:
                begin
                    port_cfg_reg <= avs_writedata[19:0];
                    tx_timing_sel <= avs_writedata[`PCFG_TXS_LSB +: 4];
                end
                `ADDR_LVL_ADDR: lvl_addr_reg <= avs_writedata[4:0];
                default: ;
            endcase
        end
    end
end
// Per-level source table, loaded by download
always @(posedge sys_clk)
begin
    if (clk_en & done & avs_write & (avs_address == `ADDR_LVL_DATA) & (lvl_addr_reg != `LEVEL_NONE))
        level_table[lvl_addr_reg] <= avs_writedata[3:0];
end
// ============================================================
// Lock monitor on the selected reference
reg src_edge;
always @*
begin
    case (ref_sel)
        `REF_INT: src_edge = 1'b1;
        `REF_EXT: src_edge = rise[4];
        default: src_edge = rise[ref_sel[1:0]];
    endcase
end
wire src_ok = (gap_cnt_reg < GAP_CYC) & ~osc2_reg;
always @(posedge sys_clk or negedge rst_b)
begin
    if (!rst_b)
    begin
        gap_cnt_reg <= 6'h00;
        ref_prev_reg <= `REF_INT;
        osc1_reg <= 1'b0;
        osc2_reg <= 1'b0;
        tick_cnt_reg <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
        osc1_reg <= osc_fault;
        osc2_reg <= osc1_reg;
        ref_prev_reg <= ref_sel;
        if (src_edge | (ref_sel != ref_prev_reg))
            gap_cnt_reg <= 6'h00;
        else if (gap_cnt_reg != 6'h3f)
            gap_cnt_reg <= gap_cnt_reg + 6'h01;
        tick_cnt_reg <= tick ? 32'h0000_0000 : tick_cnt_reg + 32'h0000_0001;
    end
end
// ============================================================
// Candidate choice: level, then hops, then preference
reg cand_found;
reg [1:0] cand_port;
reg [4:0] cand_level;
reg [3:0] cand_hops;
reg [1:0] cand_pref;
reg auto_found;
reg [1:0] auto_port;
integer i;
always @*
begin
    cand_found = 1'b0;
    cand_port = 2'h0;
    cand_level = `LEVEL_LAST;
    cand_hops = `HOPS_MAX;
    cand_pref = 2'h3;
    auto_found = 1'b0;
    auto_port = 2'h0;
    for (i = 0; i < 4; i = i + 1)
    begin
        if (avail[i] & nbr_locked[i] & (nbr_level[i*5 +: 5] != `LEVEL_NONE)
            & (nbr_level[i*5 +: 5] <= level_reg))
        begin
            if (!cand_found | (nbr_level[i*5 +: 5] < cand_level)
                | ((nbr_level[i*5 +: 5] == cand_level) & hop_search & (nbr_hops[i*4 +: 4] < cand_hops))
                | ((nbr_level[i*5 +: 5] == cand_level) & (!hop_search | (nbr_hops[i*4 +: 4] == cand_hops))
                   & (port_cfg_reg[`PCFG_PREF_LSB + i*2 +: 2] < cand_pref)))
            begin
                cand_found = 1'b1;
                cand_port = i[1:0];
                cand_level = nbr_level[i*5 +: 5];
                cand_hops = nbr_hops[i*4 +: 4];
                cand_pref = port_cfg_reg[`PCFG_PREF_LSB + i*2 +: 2];
            end
        end
        if (avail[i] & nbr_automaster[i] & (nbr_addr[i*8 +: 8] < node_addr) & !auto_found)
        begin
            auto_found = 1'b1;
            auto_port = i[1:0];
        end
    end
end
wire [3:0] next_hops = (cand_hops == `HOPS_MAX) ? `HOPS_MAX : cand_hops + 4'h1;
wire better = cand_found & ((cand_level < level_reg)
    | (hop_search & (next_hops < hops_reg)));
// ============================================================
// Clock level state machine
always @(posedge sys_clk or negedge rst_b)
begin
    if (!rst_b)
    begin
        state_reg <= ST_APPLY;
        level_reg <= `LEVEL_FIRST;
        hops_reg <= `HOPS_MAX;
        src_port_reg <= 2'h0;
        sec_cnt_reg <= 5'h00;
        ref_sel <= `REF_INT;
        tx_locked <= 1'b0;
        tx_automaster <= 1'b0;
        ext_ref_fail <= 1'b0;
        trunk_fault <= 4'h0;
        int_clk_fail <= 1'b0;
    end
    else if (clk_en)
    begin
        int_clk_fail <= osc2_reg;
        if (tick)
            sec_cnt_reg <= sec_cnt_reg + 5'h01;
        if (restart_reg)
        begin
            level_reg <= `LEVEL_FIRST;
            state_reg <= ST_APPLY;
            tx_automaster <= 1'b0;
        end
        else
        begin
            case (state_reg)
                ST_APPLY:
                begin
                    sec_cnt_reg <= 5'h00;
                    tx_automaster <= 1'b0;
                    hops_reg <= 4'h0;
                    tx_locked <= 1'b1;
                    state_reg <= ST_LOCKED;
                    if ((level_reg == `LEVEL_NONE) | (level_reg > last_level))
                    begin
                        state_reg <= ST_AUTO;
                        ref_sel <= `REF_INT;
                        tx_automaster <= 1'b1;
                    end
                    else if (fac_avail != 4'h0)
                    begin
                        ref_sel <= {1'b0, fac_port};
                        src_port_reg <= fac_port;
                    end
                    else if (cfg_mode == `MODE_INT)
                        ref_sel <= `REF_INT;
                    else if (cfg_mode == `MODE_EXT)
                        ref_sel <= `REF_EXT;
                    else
                    begin
                        ref_sel <= `REF_INT;
                        hops_reg <= `HOPS_MAX;
                        tx_locked <= 1'b0;
                        state_reg <= ST_SEARCH;
                    end
                end
                ST_LOCKED:
                begin
                    sec_cnt_reg <= 5'h00;
                    if (!src_ok)
                    begin
                        if (ref_sel == `REF_EXT)
                            ext_ref_fail <= 1'b1;
                        else if (ref_sel != `REF_INT)
                            trunk_fault[src_port_reg] <= 1'b1;
                        ref_sel <= `REF_INT;
                        state_reg <= ST_HOLD;
                    end
                    else if (!ref_sel[2] & (cfg_mode == `MODE_SLAVE) & better)
                    begin
                        ref_sel <= {1'b0, cand_port};
                        src_port_reg <= cand_port;
                        hops_reg <= next_hops;
                    end
                end
                ST_HOLD:
                begin
                    if (sec_cnt_reg >= HOLD_S)
                    begin
                        tx_locked <= 1'b0;
                        sec_cnt_reg <= 5'h00;
                        state_reg <= ST_UNLOCKED;
                    end
                end
                ST_UNLOCKED:
                begin
                    if (sec_cnt_reg >= WAIT_S)
                    begin
                        sec_cnt_reg <= 5'h00;
                        state_reg <= ST_SEARCH;
                    end
                end
                ST_SEARCH:
                begin
                    if (cand_found)
                    begin
                        ref_sel <= {1'b0, cand_port};
                        src_port_reg <= cand_port;
                        hops_reg <= next_hops;
                        trunk_fault[cand_port] <= 1'b0;
                        tx_locked <= 1'b1;
                        state_reg <= ST_LOCKED;
                    end
                    else if (sec_cnt_reg >= SEARCH_S)
                    begin
                        level_reg <= (level_reg == `LEVEL_LAST) ? `LEVEL_NONE : level_reg + 5'h01;
                        state_reg <= ST_APPLY;
                    end
                end
                ST_AUTO:
                begin
                    if (auto_found & ref_sel[2])
                    begin
                        ref_sel <= {1'b0, auto_port};
                        src_port_reg <= auto_port;
                        hops_reg <= 4'h1;
                    end
                    else if (!ref_sel[2] & !src_ok)
                        ref_sel <= `REF_INT;
                    if (cand_found & (cand_level != `LEVEL_NONE))
                    begin
                        level_reg <= cand_level;
                        state_reg <= ST_APPLY;
                    end
                end
                default: state_reg <= ST_APPLY;
            endcase
        end
    end
end
// ============================================================
// Once-per-second status to neighbors
always @(posedge sys_clk or negedge rst_b)
begin
    if (!rst_b)
    begin
        tx_level <= `LEVEL_NONE;
        tx_hops <= `HOPS_MAX;
        tx_status_strobe <= 1'b0;
    end
    else if (clk_en)
    begin
        tx_status_strobe <= tick;
        if (tick)
        begin
            tx_level <= level_reg;
            tx_hops <= hops_reg;
        end
    end
end
endmodule // network_timing_source_select
